// file: hdl/sdpi_pkg.sv
package sdpi_pkg;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    localparam int         ADDR_W          = 32;
    localparam int         SEL_TOP_MSB     = 31;
    localparam int         SEL_TOP_LSB     = 30;
    localparam logic [1:0] SDRAM_SPACE     = 2'h1;
    localparam int         BANK_MSB        = 29;
    localparam int         BANK_LSB        = 28;
    localparam int         RSVD_MSB        = 27;
    localparam int         RSVD_LSB        = 26;
    localparam logic [1:0] RSVD_CODE       = 2'h3;

    // ------------------------------------------------------------
    // Command encodings on row strobe, column strobe, write strobe
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SDPI_CMD_NOP       = 3'b111,
        SDPI_CMD_ACTIVE    = 3'b011,
        SDPI_CMD_READ      = 3'b101,
        SDPI_CMD_WRITE     = 3'b100,
        SDPI_CMD_PRECHARGE = 3'b010,
        SDPI_CMD_REFRESH   = 3'b001,
        SDPI_CMD_MODE      = 3'b000,
        SDPI_CMD_BSTOP     = 3'b110
    } sdpi_cmd_t;

    // Requested operation from the controller core
    typedef enum logic [2:0] {
        SDPI_OP_READ      = 3'b000,
        SDPI_OP_WRITE     = 3'b001,
        SDPI_OP_ACTIVE    = 3'b010,
        SDPI_OP_PRECHARGE = 3'b011,
        SDPI_OP_REFRESH   = 3'b100,
        SDPI_OP_MODE      = 3'b101,
        SDPI_OP_SELFREF   = 3'b110,
        SDPI_OP_SUSPEND   = 3'b111
    } sdpi_op_t;

    // Bus ownership states
    typedef enum logic [1:0] {
        SDPI_ST_OWN      = 2'b00,
        SDPI_ST_SREF     = 2'b01,
        SDPI_ST_GRANT    = 2'b10,
        SDPI_ST_SLAVE    = 2'b11
    } sdpi_state_t;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0] SEL_IDLE        = 4'hf;
    localparam logic       CKE_RESET       = 1'b1;

endpackage

// file: hdl/sdpi_mask_gen.sv
module sdpi_mask_gen
    import sdpi_pkg::*;
(
    input  wire logic is_write,
    input  wire logic odd_word,
    input  wire logic single_word,
    input  wire logic bus_32,
    output logic      low_mask,
    output logic      high_mask
);

    // Write masks; reads leave both masks inactive
    always_comb begin
        low_mask  = is_write & odd_word & ~bus_32;                  // R8 R7
        high_mask = is_write & ((~odd_word & single_word) | bus_32); // R9 R7
    end

endmodule

// file: hdl/sdpi_top.sv
// Contract
// R1: Assert one of four bank selects on each command to SDRAM space, not reserved; self-refresh asserts all four, suspend none.
// R2: Only the bus owner drives bank selects; others leave them undriven.
// R3: Row strobe low on activate marks a valid row address.
// R4: Column strobe low on reads and writes marks a valid column address.
// R5: Other operations use standard SDRAM encodings on the three strobes.
// R6: Write strobe low for writes, high for reads while column strobe active.
// R7: Masks meaningful only with column strobe; both inactive on reads.
// R8: Low mask set on odd-word writes to a 64-bit bus.
// R9: High mask set on even single-word writes or any 32-bit bus write.
// R10: Dedicated address bit ten output, independent of shared address bus.
// R11: Clock enable deasserted to enter self-refresh or suspend.
// R12: Before grant, clock enable held weakly high, or low after self-refresh.
// R13: On host grant, self-refresh, float all outputs, hold until request drops.
// R14: Each command presented for one clock cycle on selects and strobes.
module sdpi_top
    import sdpi_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 sys_rst,
    input  wire logic                 bus_owner,
    input  wire logic                 cmd_valid,
    input  wire sdpi_pkg::sdpi_op_t   cmd_op,
    input  wire logic [31:0]          cmd_addr,
    input  wire logic                 cmd_a10,
    input  wire logic                 cmd_single_word,
    input  wire logic                 cfg_bus_32,
    input  wire logic                 wake,
    input  wire logic                 host_bus_request_in,
    output logic                      cmd_ready,
    output logic                      host_bus_grant_out,
    output logic [3:0]                sdram_bank_selects_n,
    output logic                      sdram_bank_selects_oe,
    output logic                      row_strobe_n,
    output logic                      col_strobe_n,
    output logic                      sdram_write_strobe_n,
    output logic                      strobes_oe,
    output logic                      low_word_write_mask,
    output logic                      high_word_write_mask,
    output logic                      masks_oe,
    output logic                      sdram_addr_bit_ten,
    output logic                      sdram_addr_bit_ten_oe,
    output logic                      sdram_clock_enable,
    output logic                      sdram_clock_enable_oe,
    output logic                      cke_weak_high,
    output logic                      cke_weak_low
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    sdpi_state_t state_reg, state_next;
    logic [3:0]  sel_reg, sel_next;
    sdpi_cmd_t   cmd_reg, cmd_next;
    logic        lmask_reg, lmask_next;
    logic        hmask_reg, hmask_next;
    logic        a10_reg, a10_next;
    logic        cke_reg, cke_next;
    logic        sref_reg, sref_next;
    logic        oe_reg, oe_next;
    logic        sel_oe_reg, sel_oe_next;
    logic        grant_reg, grant_next;
    logic        ready_reg, ready_next;
    logic        whi_reg, whi_next;
    logic        wlo_reg, wlo_next;

    logic        in_space;
    logic        lmask_c;
    logic        hmask_c;
    logic        is_write;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    assign in_space = (cmd_addr[SEL_TOP_MSB:SEL_TOP_LSB] == SDRAM_SPACE) &&
                      (cmd_addr[RSVD_MSB:RSVD_LSB] != RSVD_CODE);
    assign is_write = (cmd_op == SDPI_OP_WRITE);

    sdpi_mask_gen u_mask (
        .is_write    (is_write),
        .odd_word    (cmd_addr[0]),
        .single_word (cmd_single_word),
        .bus_32      (cfg_bus_32),
        .low_mask    (lmask_c),
        .high_mask   (hmask_c)
    );

    // Next-state logic for command path and bus ownership
    always_comb begin
        state_next  = state_reg;
        sel_next    = SEL_IDLE;
        cmd_next    = SDPI_CMD_NOP;                     // R14
        lmask_next  = 1'b0;
        hmask_next  = 1'b0;
        a10_next    = a10_reg;
        cke_next    = cke_reg;
        sref_next   = sref_reg;
        oe_next     = 1'b1;
        sel_oe_next = 1'b1;
        grant_next  = 1'b0;
        whi_next    = 1'b0;
        wlo_next    = 1'b0;
        ready_next  = 1'b0;
        unique case (state_reg)
            SDPI_ST_OWN: begin
                ready_next = ~host_bus_request_in & bus_owner;
                if (!bus_owner) begin
                    state_next  = SDPI_ST_SLAVE;
                    oe_next     = 1'b0;
                    sel_oe_next = 1'b0;                 // R2
                end else if (host_bus_request_in) begin
                    // Put memory in self-refresh before letting go
                    cmd_next   = SDPI_CMD_REFRESH;      // R13
                    sel_next   = 4'h0;
                    cke_next   = 1'b0;                  // R11
                    sref_next  = 1'b1;
                    state_next = SDPI_ST_SREF;
                end else if (cmd_valid && ready_reg && in_space) begin
                    sel_next = ~(4'h1 << cmd_addr[BANK_MSB:BANK_LSB]); // R1
                    a10_next = cmd_a10;                 // R10
                    unique case (cmd_op)
                        SDPI_OP_READ:      cmd_next = SDPI_CMD_READ;      // R4 R6
                        SDPI_OP_WRITE: begin
                            cmd_next   = SDPI_CMD_WRITE;                  // R4 R6
                            lmask_next = lmask_c;                         // R7 R8
                            hmask_next = hmask_c;                         // R7 R9
                        end
                        SDPI_OP_ACTIVE:    cmd_next = SDPI_CMD_ACTIVE;    // R3
                        SDPI_OP_PRECHARGE: cmd_next = SDPI_CMD_PRECHARGE; // R5
                        SDPI_OP_REFRESH:   cmd_next = SDPI_CMD_REFRESH;   // R5
                        SDPI_OP_MODE:      cmd_next = SDPI_CMD_MODE;      // R5
                        SDPI_OP_SELFREF: begin
                            // Self-refresh reaches every chip, as on host grant
                            cmd_next  = SDPI_CMD_REFRESH;                 // R5
                            sel_next  = 4'h0;
                            cke_next  = 1'b0;                             // R11
                            sref_next = 1'b1;
                        end
                        SDPI_OP_SUSPEND: begin
                            cke_next = 1'b0;                              // R11
                            sel_next = SEL_IDLE;
                        end
                    endcase
                end else if (wake && !cke_reg) begin
                    cke_next  = 1'b1;
                    sref_next = 1'b0;
                end
            end
            SDPI_ST_SREF: begin
                // Float everything, leave weak pull on clock enable
                oe_next     = 1'b0;                     // R13
                sel_oe_next = 1'b0;
                whi_next    = ~sref_reg;                // R12
                wlo_next    = sref_reg;                 // R12
                grant_next  = 1'b1;
                state_next  = SDPI_ST_GRANT;
            end
            SDPI_ST_GRANT: begin
                oe_next     = 1'b0;
                sel_oe_next = 1'b0;
                whi_next    = ~sref_reg;                // R12
                wlo_next    = sref_reg;                 // R12
                grant_next  = host_bus_request_in;      // R13
                if (!host_bus_request_in) begin
                    // Take the pins back only if still the bus owner
                    state_next  = bus_owner ? SDPI_ST_OWN : SDPI_ST_SLAVE;
                    oe_next     = bus_owner;
                    sel_oe_next = bus_owner;            // R2
                    whi_next    = 1'b0;
                    wlo_next    = 1'b0;
                end
            end
            SDPI_ST_SLAVE: begin
                oe_next     = 1'b0;
                sel_oe_next = 1'b0;                     // R2
                if (bus_owner) begin
                    state_next  = SDPI_ST_OWN;
                    oe_next     = 1'b1;
                    sel_oe_next = 1'b1;
                end
            end
        endcase
    end

    // State registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_reg  <= SDPI_ST_SLAVE;
            sel_reg    <= SEL_IDLE;
            cmd_reg    <= SDPI_CMD_NOP;
            lmask_reg  <= 1'b0;
            hmask_reg  <= 1'b0;
            a10_reg    <= 1'b0;
            cke_reg    <= CKE_RESET;
            sref_reg   <= 1'b0;
            oe_reg     <= 1'b0;
            sel_oe_reg <= 1'b0;
            grant_reg  <= 1'b0;
            ready_reg  <= 1'b0;
            whi_reg    <= 1'b0;
            wlo_reg    <= 1'b0;
        end else begin
            state_reg  <= state_next;
            sel_reg    <= sel_next;
            cmd_reg    <= cmd_next;
            lmask_reg  <= lmask_next;
            hmask_reg  <= hmask_next;
            a10_reg    <= a10_next;
            cke_reg    <= cke_next;
            sref_reg   <= sref_next;
            oe_reg     <= oe_next;
            sel_oe_reg <= sel_oe_next;
            grant_reg  <= grant_next;
            ready_reg  <= ready_next;
            whi_reg    <= whi_next;
            wlo_reg    <= wlo_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ------------------------------------------------------------
    assign cmd_ready             = ready_reg;
    assign host_bus_grant_out    = grant_reg;
    assign sdram_bank_selects_n  = sel_reg;
    assign sdram_bank_selects_oe = sel_oe_reg;   // R2
    assign row_strobe_n          = cmd_reg[2];   // R3
    assign col_strobe_n          = cmd_reg[1];   // R4
    assign sdram_write_strobe_n  = cmd_reg[0];   // R6
    assign strobes_oe            = oe_reg;
    assign low_word_write_mask   = lmask_reg;
    assign high_word_write_mask  = hmask_reg;
    assign masks_oe              = oe_reg;
    assign sdram_addr_bit_ten    = a10_reg;      // R10
    assign sdram_addr_bit_ten_oe = oe_reg;
    assign sdram_clock_enable    = cke_reg;      // R11
    assign sdram_clock_enable_oe = oe_reg;
    assign cke_weak_high         = whi_reg;
    assign cke_weak_low          = wlo_reg;

endmodule

// file: test/sdpi_chk.sv
module sdpi_chk
    import sdpi_pkg::*;
(
    input wire logic              clock,
    input wire logic              sys_rst,
    input wire logic              bus_owner,
    input wire logic              cmd_valid,
    input wire sdpi_pkg::sdpi_op_t cmd_op,
    input wire logic [31:0]       cmd_addr,
    input wire logic              cmd_single_word,
    input wire logic              cfg_bus_32,
    input wire logic              host_bus_request_in,
    input wire logic              cmd_ready,
    input wire logic              host_bus_grant_out,
    input wire logic [3:0]        sdram_bank_selects_n,
    input wire logic              sdram_bank_selects_oe,
    input wire logic              row_strobe_n,
    input wire logic              col_strobe_n,
    input wire logic              sdram_write_strobe_n,
    input wire logic              strobes_oe,
    input wire logic              low_word_write_mask,
    input wire logic              high_word_write_mask,
    input wire logic              sdram_clock_enable,
    input wire logic              cke_weak_high,
    input wire logic              cke_weak_low
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [2:0] ENC [8] = '{SDPI_CMD_READ, SDPI_CMD_WRITE, SDPI_CMD_ACTIVE, SDPI_CMD_PRECHARGE,
                                      SDPI_CMD_REFRESH, SDPI_CMD_MODE, SDPI_CMD_REFRESH, SDPI_CMD_NOP};
    logic       take;
    logic       cmd_take;
    logic [2:0] exp_cmd;
    logic [1:0] exp_mask;
    // Accepted request and the pin values it should produce
    always_comb begin
        take     = cmd_valid && cmd_ready && bus_owner && !host_bus_request_in &&
                   cmd_addr[31:30] == SDRAM_SPACE && cmd_addr[27:26] != RSVD_CODE;
        cmd_take = take && cmd_op < SDPI_OP_SELFREF;
        exp_cmd  = ENC[cmd_op];
        exp_mask = {cfg_bus_32 | (~cmd_addr[0] & cmd_single_word), ~cfg_bus_32 & cmd_addr[0]};
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // A command followed by a quiet cycle
    sequence s_issue;
        cmd_take ##1 (!take && !host_bus_request_in);
    endsequence
    chk_sel_decode: assert property (cmd_take && cmd_op <= SDPI_OP_WRITE |=>
        sdram_bank_selects_n == ~(4'h1 << $past(cmd_addr[29:28]))) else $error("bank select wrong");
    chk_cmd_encode: assert property (cmd_take |=>
        {row_strobe_n, col_strobe_n, sdram_write_strobe_n} == $past(exp_cmd)) else $error("command code wrong");
    chk_one_cycle: assert property (s_issue |=>
        {row_strobe_n, col_strobe_n, sdram_write_strobe_n, sdram_bank_selects_n} == 7'h7f) else $error("held");
    chk_mask_idle: assert property ((col_strobe_n || sdram_write_strobe_n) |->
        !low_word_write_mask && !high_word_write_mask) else $error("mask outside write");
    chk_mask_write: assert property (cmd_take && cmd_op == SDPI_OP_WRITE |=>
        {high_word_write_mask, low_word_write_mask} == $past(exp_mask)) else $error("write mask wrong");
    chk_owner_oe: assert property (!bus_owner |=> !sdram_bank_selects_oe)
        else $error("select driven by non-owner");
    chk_cke_drop: assert property (take && cmd_op >= SDPI_OP_SELFREF |=> !sdram_clock_enable)
        else $error("clock enable still high");
    chk_grant_float: assert property (host_bus_grant_out |->
        !strobes_oe && !sdram_bank_selects_oe && cke_weak_low && !cke_weak_high) else $error("driven in grant");
    chk_grant_hold: assert property (host_bus_grant_out |=>
        host_bus_grant_out == $past(host_bus_request_in)) else $error("grant not tied to request");
endmodule

bind sdpi_top sdpi_chk u_chk (.*);

// file: test/sdpi_sdram_model.sv
module sdpi_sdram_model (
    input  wire logic       clock,
    input  wire logic [3:0] sel_n,
    input  wire logic       sel_oe,
    input  wire logic [2:0] cmd_n,
    input  wire logic       cmd_oe,
    input  wire logic [1:0] mask,
    input  wire logic       a10,
    input  wire logic       cke,
    input  wire logic       cke_oe,
    input  wire logic       wk_hi,
    input  wire logic       wk_lo,
    output logic            seen,
    output logic [9:0]      note,
    output logic            cke_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] sel_pin;
    logic [2:0] cmd_pin;
    logic       flip = 1'b0;
    // Floated lines settle at their pull-ups; a floated clock enable rests on the weak hold, or toggles when neither hold is on
    assign sel_pin = sel_oe ? sel_n : 4'hf;
    assign cmd_pin = cmd_oe ? cmd_n : 3'h7;
    assign cke_pin = cke_oe ? cke : (wk_hi ? 1'b1 : (wk_lo ? 1'b0 : flip));
    // Capture each selected command; masks count only while the column strobe is low
    always @(posedge clock) begin
        flip <= ~flip;
        seen <= sel_pin != 4'hf;
        note <= {cmd_pin, sel_pin, a10, cmd_pin[1] ? 2'h0 : mask};
    end
endmodule

// file: test/sdpi_top_tb_top.sv
module sdpi_top_tb_top;
    import sdpi_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, sys_rst, bus_owner, cmd_valid, cmd_a10, cmd_single_word, cfg_bus_32, wake;
    logic        host_bus_request_in, cmd_ready, host_bus_grant_out, sdram_bank_selects_oe, row_strobe_n;
    logic        col_strobe_n, sdram_write_strobe_n, strobes_oe, low_word_write_mask, high_word_write_mask;
    logic        masks_oe, sdram_addr_bit_ten, sdram_addr_bit_ten_oe, sdram_clock_enable, sdram_clock_enable_oe;
    logic        cke_weak_high, cke_weak_low, seen, cke_pin, last_a10;
    sdpi_op_t    cmd_op;
    logic [31:0] cmd_addr, r;
    logic [3:0]  sdram_bank_selects_n;
    logic [9:0]  note;
    logic [9:0]  notes_q[$];
    logic [2:0]  enc [8] = '{3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0, 3'h1, 3'h7};
    int          fails, checked, i;

    sdpi_top u_dut (.*);
    sdpi_sdram_model u_mem (.clock(clock), .sel_n(sdram_bank_selects_n), .sel_oe(sdram_bank_selects_oe),
        .cmd_n({row_strobe_n, col_strobe_n, sdram_write_strobe_n}), .cmd_oe(strobes_oe), .a10(sdram_addr_bit_ten),
        .mask({high_word_write_mask, low_word_write_mask}), .cke(sdram_clock_enable), .cke_pin(cke_pin),
        .cke_oe(sdram_clock_enable_oe), .wk_hi(cke_weak_high), .wk_lo(cke_weak_low), .seen(seen), .note(note));

    // 50 MHz clock
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic wait_on(ref logic sig, input logic lvl);
        int n;
        n = 0;
        while (sig !== lvl) begin
            @(posedge clock);
            #1 n++;
            if (n > 50) begin
                check("bounded wait", 1'b0, 1'b1);
                end_of_test();
            end
        end
    endtask

    // Drive one request and note the command the memory should see (kind 0 none, 2 all selects)
    task automatic send(input sdpi_op_t op, input logic [31:0] addr, input logic single, input logic b32,
                        input int kind);
        logic [1:0] m;
        logic       a;
        m = (op == SDPI_OP_WRITE) ? {b32 | (~addr[0] & single), ~b32 & addr[0]} : 2'h0;
        a = (kind != 0) ? 1'($urandom) : last_a10;
        if (kind != 0) last_a10 = a;
        if (kind != 0) notes_q.push_back({enc[op], kind == 2 ? 4'h0 : ~(4'h1 << addr[29:28]), a, m});
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_addr <= addr;
        cmd_a10 <= a;
        cmd_single_word <= single;
        cfg_bus_32 <= b32;
    endtask

    task automatic idle();
        @(posedge clock);
        cmd_valid <= 1'b0;
    endtask

    task automatic wake_up();
        @(posedge clock);
        wake <= 1'b1;
        @(posedge clock);
        wake <= 1'b0;
        wait_on(sdram_clock_enable, 1'b1);
        wait_on(cmd_ready, 1'b1);
    endtask

    // Each command seen at the memory pins is matched to the oldest note
    always @(posedge clock) begin
        if (seen === 1'b1) begin
            if (notes_q.size() == 0) check("unexpected command", 1'b1, 1'b0);
            else check("command", note, notes_q.pop_front());
        end
    end

    // Main sequence
    initial begin
        sys_rst = 1'b1;
        bus_owner = 1'b1;
        {cmd_valid, cmd_a10, cmd_single_word, cfg_bus_32, wake, host_bus_request_in, last_a10} = 7'h0;
        cmd_op = SDPI_OP_READ;
        cmd_addr = 32'h0;
        r = $urandom(32'hf219);
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        wait_on(cmd_ready, 1'b1);
        for (i = 0; i < 6; i++) send(sdpi_op_t'(i), {2'h1, 2'(i), 28'h10}, 1'b0, 1'b0, 1);
        send(SDPI_OP_READ, 32'h0000_0010, 1'b0, 1'b0, 0);
        send(SDPI_OP_WRITE, 32'h6c00_0000, 1'b0, 1'b0, 0);
        for (i = 0; i < 16; i++) begin
            r = $urandom;
            send(sdpi_op_t'({2'h0, r[5]}), {2'h1, r[1:0], 27'h0, r[2]}, r[3], r[4], 1);
        end
        idle();
        $display("test commands done");
        for (i = 6; i < 8; i++) begin
            send(sdpi_op_t'(i), 32'h5000_0000, 1'b0, 1'b0, (i == 6) ? 2 : 0);
            idle();
            @(posedge clock);
            #1 check("low power clock enable", cke_pin, 1'b0);
            wake_up();
        end
        $display("test low power done");
        notes_q.push_back({3'h1, 4'h0, last_a10, 2'h0});
        @(posedge clock);
        host_bus_request_in <= 1'b1;
        wait_on(host_bus_grant_out, 1'b1);
        check("floated outputs", {strobes_oe, sdram_bank_selects_oe, masks_oe, sdram_addr_bit_ten_oe}, 4'h0);
        check("weak clock enable", cke_pin, 1'b0);
        repeat (6) @(posedge clock);
        #1 check("grant held", host_bus_grant_out, 1'b1);
        @(posedge clock);
        host_bus_request_in <= 1'b0;
        wait_on(host_bus_grant_out, 1'b0);
        wake_up();
        $display("test host grant done");
        @(posedge clock);
        bus_owner <= 1'b0;
        send(SDPI_OP_READ, 32'h5000_0000, 1'b0, 1'b0, 0);
        idle();
        #1 check("select drive off", sdram_bank_selects_oe, 1'b0);
        @(posedge clock);
        bus_owner <= 1'b1;
        wait_on(cmd_ready, 1'b1);
        repeat (4) @(posedge clock);
        check("notes left", notes_q.size(), 0);
        $display("test ownership done");
        end_of_test();
    end
endmodule
